// [hbgp_cfg.svh]
`ifndef HBGP_CFG_SVH
`define HBGP_CFG_SVH

// System clock.
`define CLK_MHZ        50
`define CLK_PERIOD_NS  (1000 / `CLK_MHZ)
`define CYC_UP(ns)     (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Dead time settings in ns.
`define DEAD0_NS       100
`define DEAD1_NS       200
`define DEAD2_NS       400
`define DEAD3_NS       2000

// Short check mask time settings in ns.
`define BLANK0_NS      500
`define BLANK1_NS      1000
`define BLANK2_NS      2000

// Register byte offsets.
`define OFS_CTRL       6'h00
`define OFS_SENSE      6'h04
`define OFS_FLAGS      6'h08
`define OFS_IRQ_STAT   6'h0c
`define OFS_IRQ_MASK   6'h10

// Register widths and reset values.
`define CTRL_W         11
`define CTRL_RST       11'h000
`define SENSE_W        2
`define SENSE_RST      2'h0
`define FLAGS_W        6
`define STAT_W         12
`define STAT_RST       12'h000

// Event status bit positions.
`define ST_HS_LSB      0
`define ST_LS_LSB      4
`define ST_UV          8
`define ST_OV          9
`define ST_OT          10
`define ST_PUMP        11

`endif

// [hbgp_pkg.sv]
package hbgp_pkg;

  typedef enum logic [1:0] {
    LEG_OFF,
    LEG_DEAD,
    LEG_HIGH,
    LEG_LOW
  } leg_state_type;

  typedef struct packed {
    logic [1:0] ot_sel;
    logic [1:0] ov_sel;
    logic       uv_alt;
    logic       uv_off;
    logic [1:0] blank_sel;
    logic [1:0] dead_sel;
    logic       stage_en;
  } gate_ctrl_type;

  typedef struct packed {
    logic       stage_on;
    logic       over_temp;
    logic       supply_over;
    logic       supply_under;
    logic       regulator_good;
    logic       pump_good;
  } supply_flags_type;

endpackage

// [gate_leg.sv]
`timescale 1ns/1ns
`default_nettype none
`include "hbgp_cfg.svh"

module gate_leg
  import hbgp_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Control.
  input  wire logic       pwm,
  input  wire logic       allow,
  input  wire logic [6:0] dead_cyc,
  input  wire logic [6:0] blank_cyc,
  // Switch node sense.
  input  wire logic       sw_high,
  // Gates and short events.
  output logic            hs_r,
  output logic            ls_r,
  output logic            hs_short_r,
  output logic            ls_short_r
);

  leg_state_type state_r;
  leg_state_type state_nxt;
  logic [6:0]    cnt_r;
  logic [6:0]    cnt_nxt;
  logic [6:0]    blank_r;
  logic [6:0]    off_cnt_r;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      LEG_OFF:
      begin
        if (allow)
        begin
          state_nxt = LEG_DEAD;
          cnt_nxt   = dead_cyc;
        end
      end
      LEG_DEAD:
      begin
        if (!allow)
          state_nxt = LEG_OFF;
        else if (cnt_r <= 7'h01)
          state_nxt = pwm ? LEG_HIGH : LEG_LOW;
        else
          cnt_nxt = cnt_r - 7'h01;
      end
      LEG_HIGH:
      begin
        if (!allow)
          state_nxt = LEG_OFF;
        else if (!pwm)
        begin
          state_nxt = LEG_DEAD;
          cnt_nxt   = dead_cyc;
        end
      end
      LEG_LOW:
      begin
        if (!allow)
          state_nxt = LEG_OFF;
        else if (pwm)
        begin
          state_nxt = LEG_DEAD;
          cnt_nxt   = dead_cyc;
        end
      end
      default: state_nxt = LEG_OFF;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= LEG_OFF;
      cnt_r   <= 7'h00;
      hs_r    <= 1'b0;
      ls_r    <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      hs_r    <= (state_nxt == LEG_HIGH);
      ls_r    <= (state_nxt == LEG_LOW);
    end
  end

  // Mask restarts on each turn-on so switching ringing is never a short.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      blank_r <= 7'h00;
    else if (state_nxt != state_r)
      blank_r <= blank_cyc;
    else if (blank_r != 7'h00)
      blank_r <= blank_r - 7'h01;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hs_short_r <= 1'b0;
      ls_short_r <= 1'b0;
    end
    else
    begin
      hs_short_r <= ls_r && allow && (blank_r == 7'h00) && sw_high;
      ls_short_r <= hs_r && allow && (blank_r == 7'h00) && !sw_high;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      off_cnt_r <= 7'h00;
    else if (hs_r || ls_r)
      off_cnt_r <= 7'h00;
    else if (off_cnt_r != 7'h7f)
      off_cnt_r <= off_cnt_r + 7'h01;
  end

  a_no_overlap: assert property (@(posedge clk) disable iff (rst)
    !(hs_r && ls_r)) else $error("both gates of a leg on");

  a_dead_gap: assert property (@(posedge clk) disable iff (rst)
    ($rose(hs_r) || $rose(ls_r)) |-> off_cnt_r >= dead_cyc)
    else $error("dead time too short");

  a_high_follows: assert property (@(posedge clk) disable iff (rst)
    hs_r |-> $past(pwm) && !ls_r) else $error("upper gate without pwm high");

  a_upper_short: assert property (@(posedge clk) disable iff (rst)
    hs_short_r |-> $past(ls_r) && $past(sw_high) && $past(blank_r) == 7'h00)
    else $error("upper short flagged wrongly");

  a_lower_short: assert property (@(posedge clk) disable iff (rst)
    ls_short_r |-> $past(hs_r) && !$past(sw_high) && $past(blank_r) == 7'h00)
    else $error("lower short flagged wrongly");

  a_blank_mask: assert property (@(posedge clk) disable iff (rst)
    ($rose(hs_r) && blank_cyc > 7'h02) |-> !ls_short_r [*2])
    else $error("short check not masked after turn-on");

endmodule // gate_leg

`default_nettype wire

// [half_bridge_gate_protection.sv]
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "hbgp_cfg.svh"

module half_bridge_gate_protection
  import hbgp_pkg::*;
(
  // Clock and reset.
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  // Avalon-MM register slave.
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // PWM commands from the controller.
  input  wire logic [3:0]  PWM_IN,
  // Analog threshold detectors.
  input  wire logic [3:0]  SWITCH_NODE_HIGH,
  input  wire logic        PUMP_GOOD,
  input  wire logic        REGULATOR_GOOD,
  input  wire logic        SUPPLY_UNDER,
  input  wire logic        SUPPLY_OVER,
  input  wire logic        OVER_TEMP,
  // Gate drives.
  output logic [3:0]       HIGH_GATE,
  output logic [3:0]       LOW_GATE,
  // Power and sensing control.
  output logic             PUMP_ENABLE,
  output logic             SENSE_ENABLE,
  output logic [1:0]       SENSE_SELECT,
  output logic             UNDER_LEVEL_ALT,
  output logic [1:0]       OVER_LEVEL_SELECT,
  output logic [1:0]       TEMP_LEVEL_SELECT,
  // Interrupt.
  output logic             IRQ
);

  gate_ctrl_type     ctrl_r;
  logic [1:0]        sense_r;
  logic [11:0]       stat_r;
  logic [11:0]       mask_r;
  logic [11:0]       event_set;
  logic              ack_r;
  logic [31:0]       rdata_r;
  logic              wr_fire;
  logic              rd_take;
  logic [31:0]       rd_mux;
  supply_flags_type  flags;
  logic              short_latched;
  logic              supply_fault;
  logic              pump_en_nxt;
  logic              allow;
  logic              prev_uv_r;
  logic              prev_ov_r;
  logic              prev_ot_r;
  logic              prev_pump_r;
  logic [6:0]        dead_cyc;
  logic [6:0]        blank_cyc;
  logic [3:0]        hs_short;
  logic [3:0]        ls_short;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction

  function automatic logic [6:0] dead_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    return 7'(`CYC_UP(`DEAD0_NS));
      2'h1:    return 7'(`CYC_UP(`DEAD1_NS));
      2'h2:    return 7'(`CYC_UP(`DEAD2_NS));
      default: return 7'(`CYC_UP(`DEAD3_NS));
    endcase
  endfunction

  // Only three mask settings exist; the unused code keeps the longest one.
  function automatic logic [6:0] blank_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    return 7'(`CYC_UP(`BLANK0_NS));
      2'h1:    return 7'(`CYC_UP(`BLANK1_NS));
      default: return 7'(`CYC_UP(`BLANK2_NS));
    endcase
  endfunction

  assign dead_cyc  = dead_cycles(ctrl_r.dead_sel);
  assign blank_cyc = blank_cycles(ctrl_r.blank_sel);

  // One wait state: the request is taken on its first edge and answered on
  // the second, which keeps read data registered without a bus pipeline.
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_r;
  assign wr_fire         = AVS_WRITE && ack_r;
  assign rd_take         = AVS_READ && !ack_r;
  assign AVS_READDATA    = rdata_r;

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      ack_r <= 1'b0;
    else
      ack_r <= (AVS_READ || AVS_WRITE) && !ack_r;
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS)
      `OFS_CTRL:     rd_mux[`CTRL_W-1:0]  = ctrl_r;
      `OFS_SENSE:    rd_mux[`SENSE_W-1:0] = sense_r;
      `OFS_FLAGS:    rd_mux[`FLAGS_W-1:0] = flags;
      `OFS_IRQ_STAT: rd_mux[`STAT_W-1:0]  = stat_r;
      `OFS_IRQ_MASK: rd_mux[`STAT_W-1:0]  = mask_r;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      rdata_r <= 32'h0000_0000;
    else if (rd_take)
      rdata_r <= rd_mux;
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      ctrl_r <= `CTRL_RST;
    else if (wr_fire && AVS_ADDRESS == `OFS_CTRL)
      ctrl_r <= gate_ctrl_type'(`CTRL_W'(be_merge(32'(ctrl_r),
                                                  AVS_WRITEDATA,
                                                  AVS_BYTEENABLE)));
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      sense_r <= `SENSE_RST;
    else if (wr_fire && AVS_ADDRESS == `OFS_SENSE)
      sense_r <= 2'(be_merge(32'(sense_r), AVS_WRITEDATA,
                             AVS_BYTEENABLE));
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      mask_r <= `STAT_RST;
    else if (wr_fire && AVS_ADDRESS == `OFS_IRQ_MASK)
      mask_r <= 12'(be_merge(32'(mask_r), AVS_WRITEDATA, AVS_BYTEENABLE));
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      prev_uv_r   <= 1'b0;
      prev_ov_r   <= 1'b0;
      prev_ot_r   <= 1'b0;
      prev_pump_r <= 1'b0;
    end
    else
    begin
      prev_uv_r   <= SUPPLY_UNDER;
      prev_ov_r   <= SUPPLY_OVER;
      prev_ot_r   <= OVER_TEMP;
      prev_pump_r <= PUMP_GOOD;
    end
  end

  always_comb
  begin
    event_set = 12'h000;
    event_set[`ST_HS_LSB +: 4] = hs_short;
    event_set[`ST_LS_LSB +: 4] = ls_short;
    event_set[`ST_UV]   = SUPPLY_UNDER && !prev_uv_r;
    event_set[`ST_OV]   = SUPPLY_OVER && !prev_ov_r;
    event_set[`ST_OT]   = OVER_TEMP && !prev_ot_r;
    event_set[`ST_PUMP] = !PUMP_GOOD && prev_pump_r;
  end

  // A new event in the clearing cycle wins over the write of one.
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      stat_r <= `STAT_RST;
    else if (wr_fire && AVS_ADDRESS == `OFS_IRQ_STAT)
      stat_r <= (stat_r & ~12'(be_merge(32'h0000_0000, AVS_WRITEDATA,
                                        AVS_BYTEENABLE))) | event_set;
    else
      stat_r <= stat_r | event_set;
  end

  assign IRQ = |(stat_r & mask_r);

  // Short status bits double as the fault latch so one clear releases both.
  assign short_latched = |stat_r[`ST_LS_LSB+3:`ST_HS_LSB];

  assign supply_fault = (SUPPLY_UNDER && !ctrl_r.uv_off)
                     || SUPPLY_OVER
                     || OVER_TEMP;

  assign pump_en_nxt = REGULATOR_GOOD && !supply_fault;

  // The stage returns by itself once every supply condition has let go; a latched short waits for a status clear.
  assign allow = ctrl_r.stage_en
              && PUMP_GOOD
              && pump_en_nxt
              && !short_latched;

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      PUMP_ENABLE  <= 1'b0;
      SENSE_ENABLE <= 1'b0;
    end
    else
    begin
      PUMP_ENABLE  <= pump_en_nxt;
      SENSE_ENABLE <= !supply_fault;
    end
  end

  assign SENSE_SELECT      = sense_r;
  assign UNDER_LEVEL_ALT   = ctrl_r.uv_alt;
  assign OVER_LEVEL_SELECT = ctrl_r.ov_sel;
  assign TEMP_LEVEL_SELECT = ctrl_r.ot_sel;

  always_comb
  begin
    flags.stage_on       = allow;
    flags.over_temp      = OVER_TEMP;
    flags.supply_over    = SUPPLY_OVER;
    flags.supply_under   = SUPPLY_UNDER;
    flags.regulator_good = REGULATOR_GOOD;
    flags.pump_good      = PUMP_GOOD;
  end

  for (genvar ch = 0; ch < 4; ch++)
  begin : g_leg
    gate_leg u_leg (
      .clk        (SYS_CLK),
      .rst        (SYS_RST),
      .pwm        (PWM_IN[ch]),
      .allow      (allow),
      .dead_cyc   (dead_cyc),
      .blank_cyc  (blank_cyc),
      .sw_high    (SWITCH_NODE_HIGH[ch]),
      .hs_r       (HIGH_GATE[ch]),
      .ls_r       (LOW_GATE[ch]),
      .hs_short_r (hs_short[ch]),
      .ls_short_r (ls_short[ch])
    );
  end

  sequence s_short_seen;
    (|hs_short) || (|ls_short);
  endsequence

  sequence s_all_off;
    (HIGH_GATE == 4'h0) && (LOW_GATE == 4'h0);
  endsequence

  a_short_kill: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    s_short_seen |-> ##2 s_all_off [*2])
    else $error("gates not all off after a short");

  a_short_hold: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (short_latched && !(wr_fire && AVS_ADDRESS == `OFS_IRQ_STAT))
    |=> short_latched ##0 s_all_off)
    else $error("short latch lost without a clear");

  a_pump_gate: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !PUMP_GOOD |=> s_all_off) else $error("gates on without pump good");

  a_reg_gate: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !REGULATOR_GOOD |=> !PUMP_ENABLE ##0 s_all_off)
    else $error("pump or gates on without regulator good");

  a_under_off: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (SUPPLY_UNDER && !ctrl_r.uv_off) |=> !PUMP_ENABLE && !SENSE_ENABLE)
    else $error("undervoltage did not shut down");

  a_under_bypass: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (ctrl_r.uv_off && REGULATOR_GOOD && !SUPPLY_OVER && !OVER_TEMP)
    |=> PUMP_ENABLE && SENSE_ENABLE)
    else $error("disabled undervoltage still shut down");

  a_over_off: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    SUPPLY_OVER |=> !PUMP_ENABLE && !SENSE_ENABLE ##0 s_all_off)
    else $error("overvoltage did not shut down");

  a_temp_off: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    OVER_TEMP |=> !PUMP_ENABLE && !SENSE_ENABLE ##0 s_all_off)
    else $error("over-temperature did not shut down");

  a_sense_word: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (wr_fire && AVS_ADDRESS == `OFS_SENSE && AVS_BYTEENABLE[0])
    |=> SENSE_SELECT == $past(AVS_WRITEDATA[1:0]))
    else $error("sense selection not taken");

  a_restart_ok: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    ((HIGH_GATE | LOW_GATE) != 4'h0) |-> $past(allow))
    else $error("gate on while a protection was active");

  a_bus_answer: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
    else $error("bus answer later than one wait state");

endmodule // half_bridge_gate_protection

`default_nettype wire

// [hbgp_bridge_model.sv]
`timescale 1ns/1ns
`default_nettype none

module hbgp_bridge_model #(
  parameter int RISE = 8
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Gates and pump control from the block.
  input  wire logic [3:0] high_gate,
  input  wire logic [3:0] low_gate,
  input  wire logic       pump_enable,
  // Fault injection from the bench.
  input  wire logic       pump_ok,
  input  wire logic [3:0] short_hi,
  input  wire logic [3:0] short_lo,
  // Detector flags.
  output logic [3:0]      node_high,
  output logic            pump_good
);
  logic [3:0] float_r;
  int         rise_r;

  // A node with both transistors off floats, so it never shows a clean level.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      float_r <= 4'h5;
    else
      float_r <= ~float_r;

  // A shorted transistor pins the node whatever the gates say.
  always_comb
    node_high = short_hi | (~short_lo & (high_gate | (~low_gate & float_r)));

  // The pump needs time to charge, so the block must cope with a slow good.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      rise_r <= 0;
    else if (!(pump_enable && pump_ok))
      rise_r <= 0;
    else if (rise_r < RISE)
      rise_r <= rise_r + 1;

  assign pump_good = pump_ok && pump_enable && rise_r == RISE;
endmodule // hbgp_bridge_model

`default_nettype wire

// [tb_half_bridge_gate_protection.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_half_bridge_gate_protection
  import hbgp_pkg::*;
;
  logic          clk, wait_req, pen, sen, ualt, irq, pgood;
  logic          rst = 1'b1, rd = 1'b0, wr = 1'b0, rgood = 1'b1;
  logic          pump_ok = 1'b1;
  logic [5:0]    addr = 6'h00;
  logic [31:0]   wdata = 32'h0, rdata, q;
  logic [3:0]    be = 4'h0, pwm = 4'h0, sh_hi = 4'h0, sh_lo = 4'h0;
  logic [3:0]    node, hg, lg;
  logic [2:0]    flt = 3'h0;
  logic [1:0]    ssel, osel, tsel;
  int            miscompares = 0, check_count = 0, n;
  int            dt[4] = '{5, 10, 20, 100};
  int            bt[4] = '{25, 50, 100, 100};
  gate_ctrl_type c;

  half_bridge_gate_protection half_bridge_gate_protection_i (
    .SYS_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .PWM_IN(pwm),
    .SWITCH_NODE_HIGH(node), .PUMP_GOOD(pgood), .REGULATOR_GOOD(rgood),
    .SUPPLY_UNDER(flt[0]), .SUPPLY_OVER(flt[1]), .OVER_TEMP(flt[2]),
    .HIGH_GATE(hg), .LOW_GATE(lg), .PUMP_ENABLE(pen), .SENSE_ENABLE(sen),
    .SENSE_SELECT(ssel), .UNDER_LEVEL_ALT(ualt), .OVER_LEVEL_SELECT(osel),
    .TEMP_LEVEL_SELECT(tsel), .IRQ(irq));

  hbgp_bridge_model hbgp_bridge_model_i (
    .clk(clk), .rst(rst), .high_gate(hg), .low_gate(lg), .pump_enable(pen),
    .pump_ok(pump_ok), .short_hi(sh_hi), .short_lo(sh_lo),
    .node_high(node), .pump_good(pgood));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", s, e, g);
    end
  endtask

  task automatic chk_rng(input string s, input int lo, hi, g);
    check_count++;
    if (g < lo || g > hi)
    begin
      miscompares++;
      $display("[ERR] %s expected %0d..%0d seen %0d", s, lo, hi, g);
    end
  endtask

  // Holds the request until waitrequest is seen low, then settles.
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int   k;
    logic ws;
    k = 0;
    ws = 1'b1;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    // Waitrequest is combinational, so it is looked at where it has settled.
    do
    begin
      @(negedge clk);
      ws = wait_req;
      @(posedge clk);
      k++;
    end
    while (ws !== 1'b0 && k < 50);
    if (ws !== 1'b0)
    begin
      miscompares++;
      close_out();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(negedge clk);
  endtask

  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rreg(input string s, input logic [5:0] a,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(s, e, q);
  endtask

  task automatic wait_gates(input logic [7:0] e);
    n = 0;
    while ({hg, lg} !== e && n < 400)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic short_run(input int bs, input logic up);
    wreg(6'h00, 32'h0);
    @(posedge clk);
    pwm <= up ? 4'hf : 4'h0;
    if (up)
      sh_lo <= 4'h4;
    else
      sh_hi <= 4'h4;
    wreg(6'h00, 32'h1 | (bs << 3));
    wait_gates(up ? 8'hf0 : 8'h0f);
    wait_gates(8'h00);
    chk_rng("mask_time", bt[bs], bt[bs] + 4, n);
    rreg("short_bit", 6'h0c, up ? 32'h40 : 32'h4);
    wreg(6'h10, 32'h0);
    chk("irq_masked", 0, irq);
    wreg(6'h10, 32'hff);
    chk("irq_raised", 1, irq);
    repeat (20) @(negedge clk);
    chk("held_off", 0, {hg, lg});
    @(posedge clk);
    sh_lo <= 4'h0;
    sh_hi <= 4'h0;
    wreg(6'h0c, 32'hff);
    chk("irq_cleared", 0, irq);
    wait_gates(up ? 8'hf0 : 8'h0f);
    chk("restart", up ? 8'hf0 : 8'h0f, {hg, lg});
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rreg("ctrl", 6'h00, 32'h0);
    rreg("stat", 6'h0c, 32'h0);
    rreg("mask", 6'h10, 32'h0);
    wreg(6'h14, 32'hffffffff);
    rreg("unmapped", 6'h14, 32'h0);
    chk("reset_gates", 0, {hg, lg});
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      wreg(6'h04, i);
      chk("sense_sel", i, ssel);
      rreg("sense", 6'h04, i);
      c = '0;
      c.uv_alt = i[0];
      c.ov_sel = 2'(i);
      c.ot_sel = 2'(3 - i);
      wreg(6'h00, {21'h0, c});
      chk("levels", {i[0], 2'(i), 2'(3 - i)},
          {ualt, osel, tsel});
    end
    bus(1'b1, 6'h04, 32'h0, 4'h0);
    rreg("sense_lanes", 6'h04, 32'h3);
    $display("test select done");
    for (int d = 0; d < 4; d++)
    begin
      // The new dead setting must be in place before the next turn-over.
      wreg(6'h00, 32'h1 | (d << 1));
      @(posedge clk);
      pwm <= 4'hf;
      wait_gates(8'hf0);
      chk("upper_on", 8'hf0, {hg, lg});
      @(posedge clk);
      pwm <= 4'h0;
      n = 0;
      repeat (130)
      begin
        @(negedge clk);
        n += int'(hg[0] === 1'b0 && lg[0] === 1'b0);
      end
      chk("dead_time", dt[d], n);
      chk("lower_on", 8'h0f, {hg, lg});
    end
    $display("test dead time done");
    for (int b = 0; b < 4; b++)
      short_run(b, b[0]);
    $display("test short done");
    wreg(6'h00, 32'h1);
    @(posedge clk);
    pwm <= 4'hf;
    for (int p = 0; p < 3; p++)
    begin
      wait_gates(8'hf0);
      @(posedge clk);
      flt <= 3'(1 << p);
      repeat (3) @(negedge clk);
      chk("shutdown", 0, {hg, lg, pen, sen});
      rreg("event", 6'h0c, 32'h800 | (32'h100 << p));
      wreg(6'h0c, 32'hfff);
      @(posedge clk);
      flt <= 3'h0;
      wait_gates(8'hf0);
      chk("resume", 10'h3c3, {hg, lg, pen, sen});
    end
    @(posedge clk);
    flt <= 3'h5;
    repeat (3) @(posedge clk);
    flt <= 3'h1;
    repeat (40) @(negedge clk);
    chk("one_left", 0, {hg, lg, pen, sen});
    @(posedge clk);
    flt <= 3'h0;
    wait_gates(8'hf0);
    chk("all_clear", 10'h3c3, {hg, lg, pen, sen});
    $display("test supply done");
    wreg(6'h00, 32'h21);
    @(posedge clk);
    flt <= 3'h1;
    repeat (10) @(negedge clk);
    chk("uv_ignored", 10'h3c3, {hg, lg, pen, sen});
    rreg("flags", 6'h08, 32'h27);
    @(posedge clk);
    flt <= 3'h0;
    wreg(6'h0c, 32'hfff);
    @(posedge clk);
    pump_ok <= 1'b0;
    repeat (3) @(negedge clk);
    chk("pump_low", 10'h003, {hg, lg, pen, sen});
    rreg("pump_event", 6'h0c, 32'h800);
    @(posedge clk);
    pump_ok <= 1'b1;
    wait_gates(8'hf0);
    @(posedge clk);
    rgood <= 1'b0;
    repeat (3) @(negedge clk);
    chk("reg_low", 10'h001, {hg, lg, pen, sen});
    @(posedge clk);
    rgood <= 1'b1;
    wait_gates(8'hf0);
    chk("reg_back", 10'h3c3, {hg, lg, pen, sen});
    $display("test pump done");
    close_out();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    close_out();
  end
endmodule // tb_half_bridge_gate_protection

`default_nettype wire
